// [rtl/filter_config_setup3.sv]
`timescale 1ns/10ps

// Contract
// - rate code picks output rate for setup 3; code 00000 is 250 kSPS
// - direct map bit makes low fifteen bits the sinc3 decimation value; the write mask holds bits 14:12 and 7 at zero
// - while direct map is set, all other filter options are ignored
// - post filter applies only while its enable bit is one
// - post select 010 gives 27 SPS, 47 dB, 36.7 ms settling
// - post select 011 gives 25 SPS, 62 dB, 40 ms settling
// - filter order resets to sinc5 plus sinc1; other order is sinc3
// - filter order code 00 is sinc5 plus sinc1, reset value zero
module filter_config_setup3
  import filter_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // decoded setup to the filter datapath
  output filter_setup_s    filter_setup,
  output logic [15:0]      config_word
);

  // ==========================================================================
  // storage
  logic [15:0]   config_q;
  logic [7:0]    awaddr_q;
  logic          aw_held_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          w_held_q;
  filter_setup_s setup_d;
  filter_setup_s setup_q;
  filter_mode_e  mode;
  logic          do_write;
  logic [15:0]   merged;
  logic          write_hit;

  // merge byte lanes of a write into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : lane_merge

  // ==========================================================================
  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  // hold the write address once accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // hold the write data once accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // the write commits one cycle after both halves are in
  assign do_write  = aw_held_q && w_held_q;
  assign write_hit = awaddr_q == ADDR_SETUP3_FILTER_CONFIG;
  assign merged    = lane_merge(config_q, wdata_q, wstrb_q);

  // config register; reserved bits forced low in case the host slips
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= SETUP3_FILTER_CONFIG_RST;
    end else if (do_write && write_hit) begin
      config_q <= merged & CONFIG_WMASK;
    end
  end

  // write response; unmapped or read-only address answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // read channel: answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        ADDR_SETUP3_FILTER_CONFIG: begin
          s_axi_rdata <= {16'h0000, config_q};
          s_axi_rresp <= RESP_OKAY;
        end
        ADDR_FILTER_STATUS: begin
          s_axi_rdata <= {8'h00, setup_q.decim_value[7:0],
                          setup_q.post_active, setup_q.sinc3_order,
                          setup_q.direct_map, setup_q.rate_code,
                          setup_q.post_select, 5'h00};
          s_axi_rresp <= RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // decode of the filter setup
  assign mode = config_q[DIRECT_MAP_BIT] ? MODE_DIRECT_DECIM
                                         : MODE_RATE_TABLE;

  // direct map overrides every table-based option
  always_comb begin
    setup_d = '0;
    case (mode)
      MODE_DIRECT_DECIM: begin
        setup_d.direct_map  = 1'b1;
        setup_d.decim_value = config_q[DECIM_HI:RATE_LO];
        setup_d.sinc3_order = 1'b1;
        setup_d.post_active = 1'b0;
        setup_d.rate_code   = RATE_FASTEST;
        setup_d.post_select = 3'h0;
      end
      MODE_RATE_TABLE: begin
        setup_d.rate_code   = config_q[RATE_HI:RATE_LO];
        // any order code other than 00 counts as sinc3
        setup_d.sinc3_order =
          config_q[ORDER_HI:ORDER_LO] != ORDER_SINC5_1;
        // post filter only while enabled; it needs sinc5+sinc1 to work
        setup_d.post_active = config_q[POST_EN_BIT] &&
          config_q[ORDER_HI:ORDER_LO] == ORDER_SINC5_1;
        // 010 is 27 SPS, 011 is 25 SPS; passed to the post filter
        setup_d.post_select = config_q[POST_SEL_HI:POST_SEL_LO];
      end
      default: begin
        setup_d = '0;
      end
    endcase
  end

  // registered so the datapath sees a glitch-free setup
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_q <= '0;
    end else begin
      setup_q <= setup_d;
    end
  end

  assign filter_setup = setup_q;
  assign config_word  = config_q;

endmodule : filter_config_setup3

// [rtl/filter_cfg_pkg.sv]
package filter_cfg_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0]  ADDR_SETUP3_FILTER_CONFIG = 8'h00;
  localparam logic [7:0]  ADDR_FILTER_STATUS        = 8'h04;
  localparam logic [15:0] SETUP3_FILTER_CONFIG_RST  = 16'h0000;

  // ==========================================================================
  // field positions of setup3_filter_config
  localparam int DIRECT_MAP_BIT   = 15;
  localparam int POST_EN_BIT      = 11;
  localparam int POST_SEL_HI      = 10;
  localparam int POST_SEL_LO      = 8;
  localparam int ORDER_HI         = 6;
  localparam int ORDER_LO         = 5;
  localparam int RATE_HI          = 4;
  localparam int RATE_LO          = 0;
  localparam int DECIM_HI         = 14;
  // writable bits; reserved positions (14:12, 7) are held at zero
  localparam logic [15:0] CONFIG_WMASK = 16'h8F7F;

  // ==========================================================================
  // encodings
  localparam logic [4:0]  RATE_FASTEST    = 5'h00;
  localparam logic [1:0]  ORDER_SINC5_1   = 2'h0;
  localparam logic [1:0]  ORDER_SINC3     = 2'h3;
  localparam logic [2:0]  POST_SEL_27SPS  = 3'h2;
  localparam logic [2:0]  POST_SEL_25SPS  = 3'h3;
  localparam logic [5:0]  DIRECT_DIV_MULT = 6'h20;

  // ==========================================================================
  // AXI4-Lite response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum {
    MODE_RATE_TABLE,
    MODE_DIRECT_DECIM
  } filter_mode_e;

  // decoded filter setup handed to the datapath
  typedef struct packed {
    logic        direct_map;
    logic [14:0] decim_value;
    logic [4:0]  rate_code;
    logic        sinc3_order;
    logic        post_active;
    logic [2:0]  post_select;
  } filter_setup_s;

endpackage : filter_cfg_pkg

// [sim/filter_cfg_sva.sv]
`timescale 1ns/10ps
module filter_cfg_sva
  import filter_cfg_pkg::*;
(
  // clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // register and decoded setup
  input wire logic [15:0]   config_word,
  input wire filter_setup_s filter_setup
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // =========================================================================
  // decode checks; the setup lags the register by one edge
  sequence s_plain;
    !config_word[15];
  endsequence

  a_rate_follow: assert property (s_plain |=>
    filter_setup.rate_code == $past(config_word[4:0])) else $error("rate");
  a_decim_value: assert property (config_word[15] |=>
    filter_setup.direct_map && filter_setup.decim_value ==
    $past(config_word[14:0])) else $error("decim");
  a_direct_only: assert property (config_word[15] |=>
    filter_setup.sinc3_order && !filter_setup.post_active &&
    filter_setup.rate_code == 5'h00) else $error("direct");
  a_post_gate: assert property (s_plain |=>
    filter_setup.post_active == $past(config_word[11] &&
    config_word[6:5] == ORDER_SINC5_1)) else $error("post en");
  a_post_27sps: assert property (s_plain ##0
    config_word[10:8] == POST_SEL_27SPS |=>
    filter_setup.post_select == POST_SEL_27SPS) else $error("sel 27");
  a_post_25sps: assert property (s_plain ##0
    config_word[10:8] == POST_SEL_25SPS |=>
    filter_setup.post_select == POST_SEL_25SPS) else $error("sel 25");
  a_order_map: assert property (s_plain |=>
    filter_setup.sinc3_order == $past(config_word[6:5] != ORDER_SINC5_1))
    else $error("order");
  a_order_reset: assert property ($rose(aresetn) |->
    config_word[6:5] == ORDER_SINC5_1 && !filter_setup.sinc3_order)
    else $error("order rst");
endmodule : filter_cfg_sva

bind filter_config_setup3 filter_cfg_sva u_filter_cfg_sva (.*);

// [sim/axi_host_model.sv]
`timescale 1ns/10ps
module axi_host_model (
  // clock
  input wire logic        aclk,
  // write side
  output logic [7:0]      s_axi_awaddr,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  input wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  // read side
  output logic [7:0]      s_axi_araddr,
  output logic            s_axi_arvalid, s_axi_rready,
  input wire logic        s_axi_arready, s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  initial {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid,
    s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
    s_axi_rready} = '0;

  // =========================================================================
  // caller may set reserved bits and a non-00 order with the post filter
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // released lines show the inverse so stale values never look valid
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!dd && s_axi_wready) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : axi_host_model

// [sim/tb_filter_config_setup3.sv]
`timescale 1ns/10ps
module tb_filter_config_setup3;
  import filter_cfg_pkg::*;
  logic          aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, d;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, r;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic          s_axi_rvalid, s_axi_rready;
  logic [15:0]   config_word;
  filter_setup_s filter_setup;
  int            n_errors = 0, n_tests = 0;
  typedef struct {logic [15:0] wd, cw, vw;} row_s;
  // write, stored word, decoded view
  row_s rows[7] = '{'{16'h0000, 16'h0000, 16'h0000},
    '{16'h0B03, 16'h0B03, 16'h006B}, '{16'h0A02, 16'h0A02, 16'h004A},
    '{16'h0A62, 16'h0A62, 16'h0052}, '{16'h021F, 16'h021F, 16'h03E2},
    '{16'h8ABC, 16'h8A3C, 16'h8A3C}, '{16'hF0FF, 16'h807F, 16'h807F}};

  filter_config_setup3 u_filter_config_setup3 (.*);
  axi_host_model u_axi_host_model (.*);

  initial forever #10 aclk = ~aclk;

  // =========================================================================
  // compare, view and verdict
  task automatic chk(input logic [31:0] s, e, input string nm);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [15:0] vw(input filter_setup_s f);
    return f.direct_map ? {1'b1, f.decim_value} : {6'h00, f.rate_code,
      f.sinc3_order, f.post_active, f.post_select};
  endfunction : vw

  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // =========================================================================
  // rows, then bus errors and a second reset
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk(config_word, 32'h0, "cfg rst");
    chk(vw(filter_setup), 32'h0, "setup rst");
    foreach (rows[i]) begin
      u_axi_host_model.wr(ADDR_SETUP3_FILTER_CONFIG, rows[i].wd, r);
      chk(r, RESP_OKAY, "bresp");
      u_axi_host_model.rd(ADDR_SETUP3_FILTER_CONFIG, d, r);
      chk(d, {16'h0, rows[i].cw}, "readback");
      chk(vw(filter_setup), rows[i].vw, "setup");
    end
    // status word is read only, so the config must survive
    u_axi_host_model.wr(ADDR_FILTER_STATUS, 32'h1F, r);
    chk(r, RESP_SLVERR, "ro bresp");
    chk(config_word, 32'h807F, "cfg kept");
    u_axi_host_model.rd(8'h08, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR}, "unmapped");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1 chk(config_word, 32'h0, "cfg rst2");
    chk(vw(filter_setup), 32'h0, "setup rst2");
    wrap_up();
  end

  // hang guard at 5000 cycles, far beyond the 66 cycles needed
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule : tb_filter_config_setup3
